// ==== rtl/ble_pkg.sv ====
`default_nettype none
package ble_pkg;
	// Boot decision states
	typedef enum logic [2:0] {
		BLE_ST_RESET  = 3'h0,
		BLE_ST_SAMPLE = 3'h1,
		BLE_ST_DECIDE = 3'h3,
		BLE_ST_APP    = 3'h2,
		BLE_ST_LOCKED = 3'h6,
		BLE_ST_OPEN   = 3'h7
	} ble_state_e;

	// Loader entry cause codes
	typedef enum logic [1:0] {
		BLE_CAUSE_NONE  = 2'h0,
		BLE_CAUSE_PIN   = 2'h1,
		BLE_CAUSE_BLANK = 2'h2,
		BLE_CAUSE_SW    = 2'h3
	} ble_cause_e;

	localparam int          BLE_PW_BITS       = 256;
	localparam int          BLE_WORD_BITS     = 32;
	localparam int          BLE_PW_WORDS      = BLE_PW_BITS / BLE_WORD_BITS;
	localparam logic [31:0] BLE_BLANK_WORD    = 32'hffffffff;
	// Factory defaults: loader enabled, fast boot off, request level high
	localparam logic        BLE_RST_LDR_EN    = 1'b1;
	localparam logic        BLE_RST_FAST_BOOT = 1'b0;
	localparam logic        BLE_RST_REQ_LEVEL = 1'b1;

	// Non-volatile configuration as seen at boot
	typedef struct packed {
		logic loader_enable;
		logic fast_boot;
		logic request_level;
	} ble_cfg_s;

	// Boot outcome
	typedef struct packed {
		logic       boot_done;
		logic       run_app;
		logic       run_loader;
		ble_cause_e cause;
	} ble_status_s;
endpackage
`default_nettype wire

// ==== rtl/ble_pw_store.sv ====
`default_nettype none
module ble_pw_store #(
	parameter int WORDS = 8,
	parameter int WIDTH = 32
) (
	// Clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     reset_n_i,
	// Write port
	input  wire logic                     wr_en_i,
	input  wire logic [$clog2(WORDS)-1:0] wr_addr_i,
	input  wire logic [WIDTH-1:0]         wr_data_i,
	// Registered read port
	input  wire logic [$clog2(WORDS)-1:0] rd_addr_i,
	output logic      [WIDTH-1:0]         rd_data_o
);
	logic [WIDTH-1:0] mem_r [WORDS];
	logic [WIDTH-1:0] rd_data_r;

	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem_r[wr_addr_i] <= wr_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_data_r <= '0;
		end else begin
			rd_data_r <= mem_r[rd_addr_i];
		end
	end

	assign rd_data_o = rd_data_r;
endmodule
`default_nettype wire

// ==== rtl/ble_boot_ctrl.sv ====
// Overview of operation
// - Enabled: sample request pin, enter on match
// - Fast boot skips the request pin check
// - Blank vector and stack force loader entry
// - Software reset with loader command enters
// - Refuse access until 256-bit password matches
// - Disable setting blocks every entry path
// - Factory default leaves the loader enabled
// - Link is UART or I2C, two signals
// - Request pin level set by config (default high), read at boot
// - External reset low reboots, re-checks request
// - UART receive input, transmit output
//
// Strobed register access and the register addresses are this design's own decisions.
`default_nettype none
module ble_boot_ctrl
	import ble_pkg::*;
#(
	parameter int PW_WORDS = ble_pkg::BLE_PW_WORDS
) (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 reset_n_i,
	input  wire logic                 ext_reset_n_i,
	// Boot inputs
	input  wire logic                 loader_request_pin_i,
	input  wire logic [31:0]          reset_vector_i,
	input  wire logic [31:0]          stack_pointer_i,
	input  wire logic                 cfg_valid_i,
	input  wire logic                 cfg_program_i,
	input  wire ble_pkg::ble_cfg_s    cfg_wdata_i,
	// Software reset request
	input  wire logic                 system_level_reset_i,
	input  wire logic                 loader_entry_cmd_i,
	// Password from host and reference
	input  wire logic                 pw_ref_wr_i,
	input  wire logic [2:0]           pw_ref_addr_i,
	input  wire logic [31:0]          pw_ref_data_i,
	input  wire logic                 pw_word_valid_i,
	input  wire logic [31:0]          pw_word_i,
	// Link selection and pins
	input  wire logic                 link_sel_i2c_i,
	input  wire logic                 loader_uart_rx_i,
	input  wire logic                 loader_tx_data_i,
	output logic                      loader_uart_tx_o,
	input  wire logic                 loader_i2c_clock_i,
	input  wire logic                 loader_i2c_data_i,
	output logic                      loader_i2c_data_o,
	output logic                      loader_i2c_data_oe_o,
	output logic                      link_rx_o,
	output logic                      link_clk_o,
	// Status
	output ble_pkg::ble_status_s      status_o,
	output logic                      access_granted_o,
	output logic                      boot_level_reset_o,
	output ble_pkg::ble_cfg_s         cfg_o
);
	import ble_pkg::*;

	//--------------------------------------------------
	// Configuration
	//--------------------------------------------------
	ble_cfg_s cfg_r, cfg_nxt;

	always_comb begin
		cfg_nxt = cfg_r;
		if (cfg_program_i && cfg_valid_i) begin
			cfg_nxt = cfg_wdata_i;
		end
	end

	// Config survives boot resets; only power-on reset loads defaults
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cfg_r <= '{loader_enable: BLE_RST_LDR_EN,
			           fast_boot:     BLE_RST_FAST_BOOT,
			           request_level: BLE_RST_REQ_LEVEL};
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	assign cfg_o = cfg_r;

	//--------------------------------------------------
	// Boot reset sources
	//--------------------------------------------------
	ble_state_e  state_r, state_nxt;
	logic sw_entry_r, sw_entry_nxt;
	logic reboot;

	// External reset low or software system reset restarts the boot
	assign reboot = !ext_reset_n_i || system_level_reset_i;
	assign boot_level_reset_o = !ext_reset_n_i;

	always_comb begin
		sw_entry_nxt = sw_entry_r;
		if (system_level_reset_i) begin
			sw_entry_nxt = loader_entry_cmd_i;
		end else if (state_r == BLE_ST_DECIDE) begin
			sw_entry_nxt = 1'b0;
		end
	end

	//--------------------------------------------------
	// Boot decision
	//--------------------------------------------------
	ble_cause_e  cause_r, cause_nxt;
	logic        req_hit_r, req_hit_nxt;
	logic        blank;
	logic        req_match;

	assign blank = (reset_vector_i == BLE_BLANK_WORD)
	            && (stack_pointer_i == BLE_BLANK_WORD);
	// Request pin compared with the configured active level
	assign req_match = (loader_request_pin_i == cfg_r.request_level);

	logic pw_ok;

	always_comb begin
		state_nxt   = state_r;
		cause_nxt   = cause_r;
		req_hit_nxt = req_hit_r;
		case (state_r)
			BLE_ST_RESET: begin
				cause_nxt   = BLE_CAUSE_NONE;
				req_hit_nxt = 1'b0;
				if (cfg_valid_i) begin
					state_nxt = BLE_ST_SAMPLE;
				end
			end
			BLE_ST_SAMPLE: begin
				req_hit_nxt = !cfg_r.fast_boot && req_match;
				state_nxt   = BLE_ST_DECIDE;
			end
			BLE_ST_DECIDE: begin
				if (!cfg_r.loader_enable) begin
					state_nxt = BLE_ST_APP;
				end else if (sw_entry_r) begin
					cause_nxt = BLE_CAUSE_SW;
					state_nxt = BLE_ST_LOCKED;
				end else if (req_hit_r) begin
					cause_nxt = BLE_CAUSE_PIN;
					state_nxt = BLE_ST_LOCKED;
				end else if (blank) begin
					cause_nxt = BLE_CAUSE_BLANK;
					state_nxt = BLE_ST_LOCKED;
				end else begin
					state_nxt = BLE_ST_APP;
				end
			end
			BLE_ST_LOCKED: begin
				if (pw_ok) begin
					state_nxt = BLE_ST_OPEN;
				end
			end
			BLE_ST_APP,
			BLE_ST_OPEN: begin
				state_nxt = state_r;
			end
			default: begin
				state_nxt = BLE_ST_RESET;
			end
		endcase
		if (reboot) begin
			state_nxt = BLE_ST_RESET;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r    <= BLE_ST_RESET;
			cause_r    <= BLE_CAUSE_NONE;
			req_hit_r  <= 1'b0;
			sw_entry_r <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			cause_r    <= cause_nxt;
			req_hit_r  <= req_hit_nxt;
			sw_entry_r <= sw_entry_nxt;
		end
	end

	//--------------------------------------------------
	// Password check
	//--------------------------------------------------
	logic [2:0]  pw_idx_r, pw_idx_nxt;
	logic        pw_bad_r, pw_bad_nxt;
	logic        pw_cmp_r, pw_cmp_nxt;
	logic [31:0] pw_hold_r, pw_hold_nxt;
	logic        pw_last_r, pw_last_nxt;
	logic        granted_r, granted_nxt;
	logic [31:0] ref_word;

	// Reference word is read one cycle late, so each host word is held for compare
	ble_pw_store #(
		.WORDS (PW_WORDS),
		.WIDTH (BLE_WORD_BITS)
	) u_pw_store (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.wr_en_i   (pw_ref_wr_i),
		.wr_addr_i (pw_ref_addr_i),
		.wr_data_i (pw_ref_data_i),
		.rd_addr_i (pw_idx_r),
		.rd_data_o (ref_word)
	);

	always_comb begin
		pw_idx_nxt  = pw_idx_r;
		pw_bad_nxt  = pw_bad_r;
		pw_cmp_nxt  = 1'b0;
		pw_hold_nxt = pw_hold_r;
		pw_last_nxt = pw_last_r;
		pw_ok       = 1'b0;
		if (pw_cmp_r) begin
			if (pw_last_r) begin
				pw_ok      = !pw_bad_r && (pw_hold_r == ref_word);
				pw_bad_nxt = 1'b0;
			end else begin
				pw_bad_nxt = pw_bad_r || (pw_hold_r != ref_word);
			end
			pw_idx_nxt = pw_last_r ? 3'h0 : pw_idx_r + 3'h1;
		end else if (pw_word_valid_i && state_r == BLE_ST_LOCKED) begin
			pw_hold_nxt = pw_word_i;
			pw_last_nxt = (pw_idx_r == 3'(PW_WORDS - 1));
			pw_cmp_nxt  = 1'b1;
		end
		if (state_r != BLE_ST_LOCKED) begin
			pw_idx_nxt = 3'h0;
			pw_bad_nxt = 1'b0;
			pw_cmp_nxt = 1'b0;
		end
		granted_nxt = (state_nxt == BLE_ST_OPEN);
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pw_idx_r  <= 3'h0;
			pw_bad_r  <= 1'b0;
			pw_cmp_r  <= 1'b0;
			pw_hold_r <= 32'h0;
			pw_last_r <= 1'b0;
			granted_r <= 1'b0;
		end else begin
			pw_idx_r  <= pw_idx_nxt;
			pw_bad_r  <= pw_bad_nxt;
			pw_cmp_r  <= pw_cmp_nxt;
			pw_hold_r <= pw_hold_nxt;
			pw_last_r <= pw_last_nxt;
			granted_r <= granted_nxt;
		end
	end

	assign access_granted_o = granted_r;

	//--------------------------------------------------
	// Link pins
	//--------------------------------------------------
	logic loader_on;
	logic tx_r, tx_nxt;
	logic sda_oe_r, sda_oe_nxt;

	assign loader_on = (state_r == BLE_ST_LOCKED) || (state_r == BLE_ST_OPEN);

	always_comb begin
		// Idle line high for UART; I2C data only ever pulls low
		tx_nxt     = 1'b1;
		sda_oe_nxt = 1'b0;
		if (loader_on && !link_sel_i2c_i) begin
			tx_nxt = loader_tx_data_i;
		end
		if (loader_on && link_sel_i2c_i) begin
			sda_oe_nxt = !loader_tx_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tx_r     <= 1'b1;
			sda_oe_r <= 1'b0;
		end else begin
			tx_r     <= tx_nxt;
			sda_oe_r <= sda_oe_nxt;
		end
	end

	assign loader_uart_tx_o     = tx_r;
	assign loader_i2c_data_o    = 1'b0;
	assign loader_i2c_data_oe_o = sda_oe_r;
	assign link_rx_o  = link_sel_i2c_i ? loader_i2c_data_i : loader_uart_rx_i;
	assign link_clk_o = link_sel_i2c_i ? loader_i2c_clock_i : 1'b0;

	//--------------------------------------------------
	// Status
	//--------------------------------------------------
	assign status_o = '{boot_done:  (state_r == BLE_ST_APP) || loader_on,
	                    run_app:    (state_r == BLE_ST_APP),
	                    run_loader: loader_on,
	                    cause:      cause_r};
endmodule
`default_nettype wire

// ==== tb/ble_host.sv ====
`default_nettype none
// ----------------------------------------
// Programming host: request pin and reset
// ----------------------------------------
module ble_host (
	// Clock
	input  wire logic clk_i,
	// Bench control
	input  wire logic req_level_i,
	input  wire logic go_i,
	// Device pins
	output var  logic loader_request_pin_o,
	output var  logic ext_reset_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		loader_request_pin_o = 1'b0;
		ext_reset_n_o = 1'b1;
	end
	// Pin is frozen through the reset pulse so the reboot sees it
	always @(posedge clk_i) begin
		loader_request_pin_o <= req_level_i;
		if (go_i) begin
			@(posedge clk_i);
			ext_reset_n_o <= 1'b0;
			repeat (3) @(posedge clk_i);
			ext_reset_n_o <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== tb/ble_boot_checker.sv ====
`default_nettype none
module ble_boot_checker (
	// Clock and reset
	input wire logic                clk_i,
	input wire logic                reset_n_i,
	// Inputs
	input wire logic                ext_reset_n_i,
	input wire logic                loader_request_pin_i,
	input wire logic                cfg_valid_i,
	input wire logic                pw_word_valid_i,
	input wire logic                link_sel_i2c_i,
	input wire logic                loader_uart_rx_i,
	input wire logic                loader_i2c_clock_i,
	input wire logic                loader_tx_data_i,
	// Outputs
	input wire logic                loader_uart_tx_o,
	input wire logic                loader_i2c_data_o,
	input wire logic                loader_i2c_data_oe_o,
	input wire logic                link_rx_o,
	input wire logic                link_clk_o,
	input wire ble_pkg::ble_status_s status_o,
	input wire logic                access_granted_o,
	input wire logic                boot_level_reset_o,
	input wire ble_pkg::ble_cfg_s    cfg_o
);
	import ble_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	a_reset_level: assert property (boot_level_reset_o == !ext_reset_n_i)
		else $error("boot reset level wrong");
	a_reset_reboot: assert property (!ext_reset_n_i |=> !status_o.boot_done)
		else $error("external reset did not restart boot");
	a_boot_delay: assert property ($rose(status_o.boot_done) |-> $past(cfg_valid_i, 3))
		else $error("boot decision at wrong moment");
	a_pin_level: assert property ($rose(status_o.run_loader) && status_o.cause == BLE_CAUSE_PIN
		|-> $past(loader_request_pin_i, 2) == cfg_o.request_level) else $error("pin entry w/o match");
	a_fast_skip: assert property ($rose(status_o.boot_done) && cfg_o.fast_boot
		|-> status_o.cause != BLE_CAUSE_PIN) else $error("pin checked in fast boot");
	a_disable_app: assert property ($rose(status_o.boot_done) && !cfg_o.loader_enable
		|-> status_o.run_app && !status_o.run_loader) else $error("loader started while disabled");
	a_grant_loader: assert property (access_granted_o |-> status_o.run_loader)
		else $error("access outside loader");
	a_grant_word: assert property ($rose(access_granted_o)
		|-> $past(pw_word_valid_i, 2) || $past(pw_word_valid_i, 3)) else $error("grant w/o word");
	a_link_idle: assert property (!status_o.run_loader && !$past(status_o.run_loader)
		|-> loader_uart_tx_o && !loader_i2c_data_oe_o) else $error("link driven outside loader");
	a_link_mux: assert property (link_sel_i2c_i ? link_clk_o == loader_i2c_clock_i
		: (!link_clk_o && link_rx_o == loader_uart_rx_i)) else $error("link select wrong");
	a_link_drive: assert property ($past(status_o.run_loader) |-> !loader_i2c_data_o &&
		($past(link_sel_i2c_i)
			? loader_uart_tx_o && loader_i2c_data_oe_o != $past(loader_tx_data_i)
			: !loader_i2c_data_oe_o && loader_uart_tx_o == $past(loader_tx_data_i)))
		else $error("loader link pins wrong");
endmodule
bind ble_boot_ctrl ble_boot_checker u_chk (
	.clk_i(clk_i), .reset_n_i(reset_n_i), .ext_reset_n_i(ext_reset_n_i),
	.loader_request_pin_i(loader_request_pin_i), .cfg_valid_i(cfg_valid_i),
	.pw_word_valid_i(pw_word_valid_i), .link_sel_i2c_i(link_sel_i2c_i),
	.loader_uart_rx_i(loader_uart_rx_i), .loader_i2c_clock_i(loader_i2c_clock_i),
	.loader_tx_data_i(loader_tx_data_i), .loader_i2c_data_o(loader_i2c_data_o),
	.loader_uart_tx_o(loader_uart_tx_o), .loader_i2c_data_oe_o(loader_i2c_data_oe_o),
	.link_rx_o(link_rx_o), .link_clk_o(link_clk_o), .status_o(status_o),
	.access_granted_o(access_granted_o), .boot_level_reset_o(boot_level_reset_o), .cfg_o(cfg_o));
`default_nettype wire

// ==== tb/tb.sv ====
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ble_pkg::*;
	logic        clk_i = 1'b0, reset_n_i, req_level, host_go, ext_reset_n, pin, prev_done;
	logic        cfg_program, sys_reset, entry_cmd, pw_ref_wr, pw_valid, link_sel, cfg_valid;
	logic        uart_rx, tx_data, i2c_clock, i2c_data, granted;
	logic [2:0]  pw_ref_addr;
	logic [31:0] vector, stack, pw_ref_data, pw_word;
	logic [31:0] pw_ref [8];
	logic [3:0]  exp_q [$];
	ble_cfg_s    cfg_wdata, cfg_o;
	ble_status_s status_o;
	int          num_errors = 0, comparisons = 0, n_done = 0, cycles = 0;
	// Fields: cfg[10:8] pin[7] blank vector/stack[6:5] sw[4] {app,loader,cause}[3:0]
	logic [10:0] cases [12] = '{11'h585, 11'h508, 11'h788, 11'h405, 11'h566, 11'h548,
		11'h766, 11'h1e8, 11'h5e5, 11'h118, 11'h517, 11'h597};
	always #5 clk_i = ~clk_i;
	ble_host u_host (.clk_i(clk_i), .req_level_i(req_level), .go_i(host_go),
		.loader_request_pin_o(pin), .ext_reset_n_o(ext_reset_n));
	ble_boot_ctrl dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ext_reset_n_i(ext_reset_n),
		.loader_request_pin_i(pin), .reset_vector_i(vector), .stack_pointer_i(stack),
		.cfg_valid_i(cfg_valid), .cfg_program_i(cfg_program), .cfg_wdata_i(cfg_wdata),
		.system_level_reset_i(sys_reset), .loader_entry_cmd_i(entry_cmd),
		.pw_ref_wr_i(pw_ref_wr), .pw_ref_addr_i(pw_ref_addr), .pw_ref_data_i(pw_ref_data),
		.pw_word_valid_i(pw_valid), .pw_word_i(pw_word), .link_sel_i2c_i(link_sel),
		.loader_uart_rx_i(uart_rx), .loader_tx_data_i(tx_data), .loader_uart_tx_o(),
		.loader_i2c_clock_i(i2c_clock), .loader_i2c_data_i(i2c_data), .loader_i2c_data_o(),
		.loader_i2c_data_oe_o(), .link_rx_o(), .link_clk_o(), .status_o(status_o),
		.access_granted_o(granted), .boot_level_reset_o(), .cfg_o(cfg_o));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ----------------------------------------
	// Result watcher and stimulus
	// ----------------------------------------
	always @(posedge clk_i) begin
		prev_done <= status_o.boot_done;
		uart_rx <= 1'($urandom);
		tx_data <= 1'($urandom);
		i2c_clock <= 1'($urandom);
		i2c_data <= 1'($urandom);
		if (status_o.boot_done === 1'b1 && prev_done === 1'b0) begin
			n_done++;
			if (exp_q.size() == 0) chk(32'h1, 32'h0);
			else chk({status_o.run_app, status_o.run_loader, status_o.cause},
				exp_q.pop_front());
		end
	end
	// Hang guard, far above the few hundred cycles needed
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			conclude();
		end
	end
	task automatic run_case(input logic [10:0] c);
		int target;
		target = n_done + 1;
		exp_q.push_back(c[3:0]);
		@(posedge clk_i);
		cfg_program <= 1'b1;
		cfg_wdata <= c[10:8];
		req_level <= c[7];
		link_sel <= 1'($urandom);
		vector <= c[6] ? BLE_BLANK_WORD : ($urandom & 32'h7fffffff);
		stack <= c[5] ? BLE_BLANK_WORD : ($urandom & 32'h7fffffff);
		@(posedge clk_i);
		cfg_program <= 1'b0;
		@(posedge clk_i);
		cfg_valid <= 1'b0;
		if (c[4]) {sys_reset, entry_cmd} <= 2'h3;
		else host_go <= 1'b1;
		@(posedge clk_i);
		{sys_reset, entry_cmd, host_go} <= 3'h0;
		// Boot has to wait in reset until the configuration reads valid
		repeat (2 + $urandom % 4) @(posedge clk_i);
		cfg_valid <= 1'b1;
		for (int i = 0; i < 60 && n_done < target; i++) @(posedge clk_i);
		chk(n_done, target);
	endtask
	task automatic send_pw(input logic bad);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i);
			pw_valid <= 1'b1;
			pw_word <= pw_ref[i] ^ {31'h0, bad && i == 3};
			@(posedge clk_i);
			pw_valid <= 1'b0;
		end
		repeat (4) @(posedge clk_i);
	endtask
	initial begin
		void'($urandom(32'hceb8));
		{reset_n_i, req_level, host_go, cfg_program, sys_reset, entry_cmd} = 6'h0;
		{pw_ref_wr, pw_valid, link_sel} = 3'h0;
		{pw_ref_addr, vector, stack, pw_ref_data, pw_word} = '0;
		cfg_wdata = '0;
		cfg_valid = 1'b1;
		exp_q.push_back(4'h8);
		repeat (8) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		chk(cfg_o, 32'h5);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i);
			pw_ref[i] = $urandom;
			pw_ref_wr <= 1'b1;
			pw_ref_addr <= 3'(i);
			pw_ref_data <= pw_ref[i];
		end
		@(posedge clk_i);
		pw_ref_wr <= 1'b0;
		repeat (10) @(posedge clk_i);
		foreach (cases[i]) run_case(cases[i]);
		run_case(11'h585);
		send_pw(1'b1);
		chk(granted, 32'h0);
		send_pw(1'b0);
		chk(granted, 32'h1);
		run_case(11'h508);
		chk(granted, 32'h0);
		conclude();
	end
endmodule
`default_nettype wire
